// ==== dsl_defs.svh ====
// constants of the drive status lamp block
`ifndef DSL_DEFS_SVH
`define DSL_DEFS_SVH
`define DSL_CLK_HZ          25000000
`define DSL_TICK_MS         50
`define DSL_TICK_CYC        ((`DSL_CLK_HZ / 1000) * `DSL_TICK_MS)
`define DSL_FLICK_MS        50
`define DSL_FLICK_CYC       ((`DSL_CLK_HZ / 1000) * `DSL_FLICK_MS)
`define DSL_ADDR_W          4
`define DSL_REG_CTRL        4'h0
`define DSL_REG_STAT        4'h1
`define DSL_REG_MASK        4'h2
`define DSL_REG_OVTH        4'h3
`define DSL_REG_BLTH        4'h4
`define DSL_REG_ERR         4'h5
`define DSL_REG_HIST        4'h6
`define DSL_REG_HPTR        4'h7
`define DSL_CTRL_LAMP_OFF   0
`define DSL_CTRL_FAULT_RST  1
`define DSL_OVTH_RST        16'h0C80
`define DSL_BLTH_RST        16'h0BB8
`define DSL_UVTH_MV         16'h2710
`define DSL_HIST_DEPTH      8
`endif

// ==== dsl_pkg.sv ====
// types of the drive status lamp block
package dsl_pkg;
    typedef enum logic [2:0]
    {
        DSL_BOOT,
        DSL_INIT,
        DSL_PREOP,
        DSL_SAFEOP,
        DSL_OP,
        DSL_BOOTSTRAP
    } dsl_slave_t;
    typedef enum logic [2:0]
    {
        DSL_ERR_NONE,
        DSL_ERR_CFG,
        DSL_ERR_LOCAL,
        DSL_ERR_WDOG,
        DSL_ERR_APP,
        DSL_ERR_BOOT,
        DSL_ERR_DEAD
    } dsl_fault_t;
endpackage

// ==== dsl_status_lamps.sv ====
// drive status lamps, supply supervision and error history
//
// Contract
// RULE_01 - no error: green power lamp, one pulse/second
// RULE_02 - on error: red lamp, flashes equal class
// RULE_03 - classes 1..6 general to watchdog reset
// RULE_04 - every error logged in readable history; a supply fault is logged only when it latches the error class
// RULE_05 - control bit turns power lamps off
// RULE_06 - port lamp steady on link, flashes traffic
// RULE_07 - state lamp off in Init
// RULE_08 - state lamp blinks evenly in Pre-Op
// RULE_09 - state lamp single flash in Safe-Op
// RULE_10 - flicker booting, steady in Operational
// RULE_11 - fault lamp off, blink config, single local
// RULE_12 - fault double watchdog, triple power machine
// RULE_13 - fault flicker boot fail, steady dead
// RULE_14 - overvoltage disables drive, raises error
// RULE_15 - above ballast threshold enable ballast switch
// RULE_16 - below 10 V disable drive, raise error
// RULE_17 - long dark pause between error bursts
// RULE_18 - bus lamp patterns from tick counter
// RULE_19 - errors latched until fault reset clears
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "dsl_defs.svh"
module dsl_status_lamps #(
    parameter int TICK_CYC  = `DSL_TICK_CYC,
    parameter int FLICK_CYC = `DSL_FLICK_CYC,
    parameter int PORTS     = 2
)(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [`DSL_ADDR_W-1:0] addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [31:0]            rdata,
    input  wire logic [15:0]            supply_mv,
    input  wire logic [2:0]             err_class_in,
    input  wire logic [15:0]            err_code_in,
    input  wire logic                   err_event,
    input  wire logic                   err_cause_active,
    input  wire dsl_pkg::dsl_slave_t    slave_state,
    input  wire dsl_pkg::dsl_fault_t    bus_fault,
    input  wire logic [PORTS-1:0]       link_up,
    input  wire logic [PORTS-1:0]       link_traffic,
    output logic                        power_lamp_green,
    output logic                        power_lamp_red,
    output logic [PORTS-1:0]            port_lamp,
    output logic                        state_lamp,
    output logic                        fault_lamp,
    output logic                        drive_enable,
    output logic                        ballast_on,
    output logic                        irq
);
    import dsl_pkg::*;

    localparam int HD = `DSL_HIST_DEPTH;

    logic [31:0]  tdiv_q;
    logic [31:0]  fdiv_q;
    logic         tick;
    logic         ftick;
    logic [4:0]   phase_q;
    logic         flick_q;
    logic         lamp_off_q;
    logic [15:0]  ovth_q;
    logic [15:0]  blth_q;
    logic [2:0]   err_q;
    logic [2:0]   stat_q;
    logic [2:0]   mask_q;
    logic [15:0]  hist_q [HD];
    logic [2:0]   hptr_q;
    logic         ov;
    logic         uv;
    logic         ev_err;
    logic [2:0]   new_class;
    logic         fault_rst;
    logic [3:0]   burst_q;
    logic [4:0]   pcnt_q;
    logic         pon;
    logic         clr_ok;
    logic [2:0]   blink_q;
    logic         sec_q;
    logic [PORTS-1:0] port_d;

    // base ticks: 50 ms pattern step, 50 ms flicker
    always_ff @(posedge clk)
    begin
        if (reset || tdiv_q == TICK_CYC - 1)
            tdiv_q <= '0;
        else
            tdiv_q <= tdiv_q + 32'h1;
    end
    assign tick = (tdiv_q == TICK_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (reset || fdiv_q == FLICK_CYC - 1)
            fdiv_q <= '0;
        else
            fdiv_q <= fdiv_q + 32'h1;
    end
    assign ftick = (fdiv_q == FLICK_CYC - 1);

    // 20 steps of 50 ms form one second
    always_ff @(posedge clk)
    begin
        if (reset)
            phase_q <= '0;
        else if (tick)
            phase_q <= (phase_q == 5'd19) ? 5'h0 : phase_q + 5'h1;
    end

    // even blink steps and a 2 s frame for the triple flash
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            blink_q <= '0;
            sec_q   <= 1'b0;
        end
        else if (tick)
        begin
            blink_q <= blink_q + 3'h1;
            if (phase_q == 5'd19)
                sec_q <= ~sec_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            flick_q <= 1'b0;
        else if (ftick)
            flick_q <= ~flick_q; // [RULE_18]
    end

    // supply supervision
    assign ov = supply_mv > ovth_q;              // [RULE_14]
    assign uv = supply_mv < `DSL_UVTH_MV;        // [RULE_16]
    assign fault_rst = wr && addr == `DSL_REG_CTRL && wdata[`DSL_CTRL_FAULT_RST];
    assign clr_ok    = fault_rst && !err_cause_active && !ov && !uv;

    always_comb
    begin
        ev_err    = 1'b0;
        new_class = 3'h0;
        if (err_event && err_class_in >= 3'h1 && err_class_in <= 3'h6)
        begin
            ev_err    = 1'b1;
            new_class = err_class_in;            // [RULE_03]
        end
        else if ((ov || uv) && err_q == 3'h0)
        begin
            ev_err    = 1'b1;
            new_class = 3'h2;
        end
    end

    // latched current error class
    always_ff @(posedge clk)
    begin
        if (reset)
            err_q <= 3'h0;
        else if (ev_err && (err_q == 3'h0 || clr_ok))
            err_q <= new_class;                  // [RULE_02]
        else if (clr_ok)
            err_q <= 3'h0;                       // [RULE_19]
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            drive_enable <= 1'b0;
        else
            drive_enable <= (err_q == 3'h0) && !ov && !uv; // [RULE_14] [RULE_16]
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            ballast_on <= 1'b0;
        else
            ballast_on <= supply_mv > blth_q;    // [RULE_15]
    end

    // error history ring
    always_ff @(posedge clk)
    begin
        if (reset)
            hptr_q <= '0;
        else if (ev_err)
        begin
            hist_q[hptr_q] <= (err_event ? err_code_in : 16'h0200) ; // [RULE_04]
            hptr_q         <= hptr_q + 3'h1;
        end
    end

    // sticky status: bit0 error, bit1 overvoltage, bit2 undervoltage
    always_ff @(posedge clk)
    begin
        if (reset)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~((wr && addr == `DSL_REG_STAT) ? wdata[2:0] : 3'h0))
                      | {uv, ov, ev_err};
    end
    assign irq = |(stat_q & mask_q);

    // register writes
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lamp_off_q <= 1'b0;
            mask_q     <= '0;
            ovth_q     <= `DSL_OVTH_RST;
            blth_q     <= `DSL_BLTH_RST;
        end
        else if (wr)
        begin
            unique case (addr)
                `DSL_REG_CTRL: lamp_off_q <= wdata[`DSL_CTRL_LAMP_OFF];
                `DSL_REG_MASK: mask_q     <= wdata[2:0];
                `DSL_REG_OVTH: ovth_q     <= wdata[15:0];
                `DSL_REG_BLTH: blth_q     <= wdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                `DSL_REG_CTRL: rdata <= {31'h0, lamp_off_q};
                `DSL_REG_STAT: rdata <= {29'h0, stat_q};
                `DSL_REG_MASK: rdata <= {29'h0, mask_q};
                `DSL_REG_OVTH: rdata <= {16'h0, ovth_q};
                `DSL_REG_BLTH: rdata <= {16'h0, blth_q};
                `DSL_REG_ERR:  rdata <= {29'h0, err_q};
                `DSL_REG_HIST: rdata <= {16'h0, hist_q[hptr_q - 3'h1]};
                `DSL_REG_HPTR: rdata <= {29'h0, hptr_q};
                default:       rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end

    // power lamp burst: 200 ms on/off pairs, then 600 ms pause
    always_ff @(posedge clk)
    begin
        if (reset || err_q == 3'h0)
        begin
            burst_q <= '0;
            pcnt_q  <= '0;
        end
        else if (tick)
        begin
            if (pcnt_q == 5'd3)
            begin
                pcnt_q  <= '0;
                burst_q <= (burst_q == {1'b0, err_q} + 4'd2) ? 4'h0 : burst_q + 4'h1; // [RULE_17]
            end
            else
                pcnt_q <= pcnt_q + 5'h1;
        end
    end
    assign pon = burst_q < {1'b0, err_q} && pcnt_q < 5'd2;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            power_lamp_green <= 1'b0;
            power_lamp_red   <= 1'b0;
        end
        else
        begin
            power_lamp_green <= !lamp_off_q && err_q == 3'h0 && phase_q < 5'd2; // [RULE_01] [RULE_05]
            power_lamp_red   <= !lamp_off_q && err_q != 3'h0 && pon;            // [RULE_02] [RULE_05]
        end
    end

    // fieldbus lamps
    always_comb
    begin
        for (int i = 0; i < PORTS; i++)
            port_d[i] = link_up[i] && (!link_traffic[i] || flick_q); // [RULE_06]
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            port_lamp <= '0;
        else
            port_lamp <= port_d;
    end

    // 50 ms units: blink even 4/4; single 4 on of 20; double/triple 4 on 4 off
    always_ff @(posedge clk)
    begin
        if (reset)
            state_lamp <= 1'b0;
        else
        begin
            unique case (slave_state)
                DSL_INIT:      state_lamp <= 1'b0;              // [RULE_07]
                DSL_PREOP:     state_lamp <= blink_q[2];        // [RULE_08] [RULE_18]
                DSL_SAFEOP:    state_lamp <= phase_q < 5'd4;    // [RULE_09]
                DSL_OP:        state_lamp <= 1'b1;              // [RULE_10]
                default:       state_lamp <= flick_q;           // [RULE_10]
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            fault_lamp <= 1'b0;
        else
        begin
            unique case (bus_fault)
                DSL_ERR_NONE:  fault_lamp <= 1'b0;                        // [RULE_11]
                DSL_ERR_CFG:   fault_lamp <= blink_q[2];                  // [RULE_11]
                DSL_ERR_LOCAL: fault_lamp <= phase_q < 5'd4;              // [RULE_11]
                DSL_ERR_WDOG:  fault_lamp <= phase_q < 5'd12 && !phase_q[2]; // [RULE_12]
                DSL_ERR_APP:   fault_lamp <= !sec_q && !phase_q[2];       // [RULE_12]
                DSL_ERR_BOOT:  fault_lamp <= flick_q;                     // [RULE_13]
                default:       fault_lamp <= 1'b1;                        // [RULE_13]
            endcase
        end
    end

    AST_UV_DRIVE: assert property (@(posedge clk) disable iff (reset)
        uv |=> !drive_enable) else $error("drive enabled under undervoltage"); // [RULE_16]
    AST_OV_DRIVE: assert property (@(posedge clk) disable iff (reset)
        ov |=> !drive_enable) else $error("drive enabled over threshold"); // [RULE_14]
    AST_BALLAST: assert property (@(posedge clk) disable iff (reset)
        (supply_mv > blth_q) |=> ballast_on) else $error("ballast not on"); // [RULE_15]
    AST_OFF: assert property (@(posedge clk) disable iff (reset)
        $past(lamp_off_q) |-> !power_lamp_green && !power_lamp_red)
        else $error("power lamp lit while off"); // [RULE_05]
    AST_GREEN_ERR: assert property (@(posedge clk) disable iff (reset)
        $past(err_q) != 3'h0 |-> !power_lamp_green) else $error("green during error"); // [RULE_01]
    AST_LATCH: assert property (@(posedge clk) disable iff (reset)
        err_q != 3'h0 && !fault_rst |=> err_q == $past(err_q)) else $error("error lost"); // [RULE_19]
    AST_INIT: assert property (@(posedge clk) disable iff (reset)
        slave_state == DSL_INIT |=> !state_lamp) else $error("state lamp lit in init"); // [RULE_07]
    AST_OPER: assert property (@(posedge clk) disable iff (reset)
        slave_state == DSL_OP |=> state_lamp) else $error("state lamp dark in op"); // [RULE_10]
    AST_HIST: assert property (@(posedge clk) disable iff (reset)
        ev_err |=> hptr_q == $past(hptr_q) + 3'h1) else $error("history not advanced"); // [RULE_04]
    AST_NOFAULT: assert property (@(posedge clk) disable iff (reset)
        bus_fault == DSL_ERR_NONE |=> !fault_lamp) else $error("fault lamp lit"); // [RULE_11]

    COV_ERR: cover property (@(posedge clk) disable iff (reset) ev_err ##1 err_q != 3'h0);
    COV_RST: cover property (@(posedge clk) disable iff (reset) fault_rst && err_q != 3'h0);
    COV_BAL: cover property (@(posedge clk) disable iff (reset) $rose(ballast_on));
endmodule

// ==== dsl_lamp_view.sv ====
// operator view of the lamps: flash and lit-cycle counts
`timescale 1ns/1ps
module dsl_lamp_view (
    input  wire logic       clk,
    input  wire logic       clear,
    input  wire logic [4:0] lamps,
    output int              rises [5],
    output int              on_cyc [5],
    output int              burst
);
    logic [4:0] prev_q;
    int         run_q = 0;
    int         dark_q = 0;
    always_ff @(posedge clk)
    begin
        prev_q <= lamps;
        for (int i = 0; i < 5; i++)
        begin
            rises[i]  <= clear ? 0 : rises[i] + int'(lamps[i] & ~prev_q[i]);
            on_cyc[i] <= clear ? 0 : on_cyc[i] + int'(lamps[i]);
        end
    end
    // red flashes split into bursts by a long dark run
    always_ff @(posedge clk)
    begin
        dark_q <= lamps[1] ? 0 : dark_q + 1;
        if (dark_q == 12 && run_q > 0)
        begin
            burst <= run_q;
            run_q <= 0;
        end
        else
            run_q <= run_q + int'(lamps[1] & ~prev_q[1]);
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench of the drive status lamp block
`timescale 1ns/1ps
module tb_top;
    import dsl_pkg::*;
    logic clk = 0, reset = 1, wr = 0, rd = 0, err_event = 0, err_cause_active = 0, clear = 0;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [15:0] supply_mv = 16'h5DC0, err_code_in = 0, code;
    logic [2:0] err_class_in = 0;
    dsl_slave_t slave_state = DSL_INIT;
    dsl_fault_t bus_fault = DSL_ERR_NONE;
    logic [1:0] link_up = 0, link_traffic = 0, port_lamp;
    logic power_lamp_green, power_lamp_red, state_lamp, fault_lamp, drive_enable, ballast_on, irq;
    int rises [5], on_cyc [5], burst, num_errors = 0, n_tests = 0;
    dsl_status_lamps #(.TICK_CYC(4), .FLICK_CYC(4), .PORTS(2)) dut (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .supply_mv(supply_mv),
        .err_class_in(err_class_in), .err_code_in(err_code_in), .err_event(err_event),
        .err_cause_active(err_cause_active), .slave_state(slave_state), .bus_fault(bus_fault),
        .link_up(link_up), .link_traffic(link_traffic), .power_lamp_green(power_lamp_green),
        .power_lamp_red(power_lamp_red), .port_lamp(port_lamp), .state_lamp(state_lamp),
        .fault_lamp(fault_lamp), .drive_enable(drive_enable), .ballast_on(ballast_on), .irq(irq));
    dsl_lamp_view view (.clk(clk), .clear(clear), .rises(rises), .on_cyc(on_cyc), .burst(burst),
        .lamps({port_lamp[0], fault_lamp, state_lamp, power_lamp_red, power_lamp_green}));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic end_sim();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, exp);
    endtask
    task automatic watch(input int n);
        @(posedge clk);
        clear <= 1;
        @(posedge clk);
        clear <= 0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // 0 dark, 1 steady, 2 flicker, 3 even blink, 4 to 6 one to three flashes
    function automatic int lamp_kind(input logic [2:0] v, input bit is_fault);
        int slave_pat [6] = '{2, 0, 3, 4, 1, 2};
        int fault_pat [7] = '{0, 3, 4, 5, 6, 2, 1};
        return is_fault ? fault_pat[v] : slave_pat[v];
    endfunction
    function automatic logic drv_ok(input logic [15:0] mv);
        return mv >= 16'h2710 && mv <= 16'hC4E0;
    endfunction
    // rises and lit cycles in 6 s, one 50 ms step being 4 cycles here
    task automatic chk_kind(input int i, input int p);
        int exp_rise [7] = '{0, 0, 60, 15, 6, 12, 9};
        int exp_on [7] = '{0, 480, 240, 240, 96, 192, 144};
        watch(480);
        chk(rises[i], exp_rise[p]);
        chk(on_cyc[i], exp_on[p]);
        @(posedge clk);
    endtask
    // lat: an error is still latched, so the drive stays off
    task automatic supply(input logic [15:0] mv, input bit lat);
        @(posedge clk);
        supply_mv <= mv;
        repeat (4) @(posedge clk);
        #1 chk(drive_enable, drv_ok(mv) && !lat);
    endtask
    task automatic recover();
        supply(16'h5DC0, 1'b1);
        wr_reg(4'h0, 32'h2);
        wr_reg(4'h1, 32'h7);
        repeat (2) @(posedge clk);
        #1 chk({irq, drive_enable}, 2'b01);
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h7E62));
        repeat (3) @(posedge clk);
        reset <= 0;
        rd_chk(4'h3, 32'h0C80);
        rd_chk(4'h4, 32'h0BB8);
        rd_chk(4'hC, 32'h0);
        wr_reg(4'h3, 32'hC4E0);
        wr_reg(4'h4, 32'hAFC8);
        wr_reg(4'h2, 32'h7);
        rd_chk(4'h5, 32'h2);
        rd_chk(4'h6, 32'h0200);
        recover();
        watch(160);
        chk(rises[0], 32'd2);
        chk(on_cyc[0], 32'd16);
        chk(on_cyc[1], 32'd0);
        wr_reg(4'h0, 32'h1);
        watch(160);
        chk(on_cyc[0] + on_cyc[1], 0);
        wr_reg(4'h0, 32'h0);
        for (int c = 1; c <= 6; c++)
        begin
            code = 16'($urandom);
            @(posedge clk);
            {err_class_in, err_code_in, err_event, err_cause_active} <= {3'(c), code, 2'b11};
            @(posedge clk);
            err_event <= 0;
            watch(300);
            chk(burst, c);
            chk(on_cyc[0], 32'd0);
            chk({irq, drive_enable}, 2'b10);
            rd_chk(4'h5, c);
            rd_chk(4'h6, code);
            wr_reg(4'h0, 32'h2);
            rd_chk(4'h5, c);
            @(posedge clk);
            err_cause_active <= 0;
            recover();
            rd_chk(4'h5, 32'h0);
        end
        supply(16'hB3B0, 1'b0);
        chk(ballast_on, 1);
        supply(16'hC738, 1'b0);
        rd_chk(4'h5, 32'h2);
        recover();
        chk(ballast_on, 0);
        supply(16'h2710, 1'b0);
        supply(16'h2328, 1'b0);
        rd_chk(4'h5, 32'h2);
        recover();
        @(posedge clk);
        for (int s = 0; s < 6; s++)
        begin
            slave_state <= dsl_slave_t'(s);
            chk_kind(2, lamp_kind(3'(s), 0));
        end
        for (int f = 0; f < 7; f++)
        begin
            bus_fault <= dsl_fault_t'(f);
            chk_kind(3, lamp_kind(3'(f), 1));
        end
        link_up <= {1'($urandom), 1'b1};
        chk_kind(4, 1);
        #1 chk(port_lamp[1], link_up[1]);
        @(posedge clk);
        link_traffic <= 2'b11;
        chk_kind(4, 2);
        link_up <= 2'b00;
        link_traffic <= 2'b00;
        chk_kind(4, 0);
        end_sim();
    end
endmodule
